// [design/call_dispatch_pkg.sv]
// constants shared by the procedure-call dispatch block and its bench
// assumes a 32-bit classic wishbone register bus and a 32-bit word memory port
package call_dispatch_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0]  REG_CMD         = 8'h00;
    localparam logic [7:0]  REG_OPERAND     = 8'h04;
    localparam logic [7:0]  REG_IP          = 8'h08;
    localparam logic [7:0]  REG_PROCESSOR_CONTROL_BLOCK        = 8'h0C;
    localparam logic [7:0]  REG_SP          = 8'h10;
    localparam logic [7:0]  REG_FP          = 8'h14;
    localparam logic [7:0]  REG_STATUS      = 8'h18;
    localparam logic [7:0]  REG_TARGET      = 8'h1C;
    localparam logic [7:0]  REG_RETTYPE     = 8'h20;
    localparam logic [7:0]  REG_TBASE       = 8'h24;
    localparam logic [7:0]  REG_SSP         = 8'h28;
    localparam logic [7:0]  REG_MODE        = 8'h2C;

    ////////////////////////////////////////////////////////////////////////////
    // command register fields
    localparam logic [1:0]  CMD_CALL        = 2'h0;
    localparam logic [1:0]  CMD_CALLX       = 2'h1;
    localparam logic [1:0]  CMD_CALLS       = 2'h2;
    localparam logic [1:0]  CMD_INIT        = 2'h3;
    localparam int          CMD_FAULT_BIT   = 2;

    // status and mode field positions
    localparam int          ST_BUSY         = 0;
    localparam int          ST_SUPER        = 1;
    localparam int          ST_TRACE        = 2;
    localparam int          ST_RANGE_ERR    = 3;
    localparam int          ST_RSVD_ERR     = 4;
    localparam int          ST_TYPE_LSB     = 8;
    localparam int          MODE_SUPER      = 0;
    localparam int          MODE_TRACE      = 1;

    ////////////////////////////////////////////////////////////////////////////
    // procedure table layout
    localparam logic [1:0]  ENTRY_LOCAL     = 2'h0;
    localparam logic [1:0]  ENTRY_SUPER     = 2'h2;
    localparam logic [2:0]  RET_LOCAL       = 3'h0;
    localparam logic [2:0]  RET_FAULT       = 3'h1;
    localparam logic [1:0]  RET_SUPER_HI    = 2'h1;
    localparam logic [31:0] TABLE_BYTES     = 32'h0000_0440;
    localparam logic [31:0] TABLE_ENTRIES   = 32'h0000_0104;
    localparam logic [31:0] TABLE_SSP_OFF   = 32'h0000_000C;
    localparam logic [31:0] TABLE_ENTRY_OFF = 32'h0000_0030;
    localparam logic [31:0] PROCESSOR_CONTROL_BLOCK_TABLE_OFF  = 32'h0000_0014;
    localparam int          DISP_W          = 24;

    // frame geometry and reset values
    localparam logic [31:0] FRAME_BYTES     = 32'h0000_0040;
    localparam logic [31:0] ALIGN_ADD       = 32'h0000_000F;
    localparam logic [31:0] ALIGN_MASK      = 32'hFFFF_FFF0;
    localparam logic [31:0] WORD_MASK       = 32'hFFFF_FFFC;
    localparam logic [31:0] RST_WORD        = 32'h0000_0000;
    localparam logic [31:0] RST_PROCESSOR_CONTROL_BLOCK        = 32'h0000_0000;

endpackage : call_dispatch_pkg

// [design/call_dispatch.sv]
// procedure-call dispatch: local calls, table calls, supervisor stack switch
// assumes a classic wishbone master and a memory that answers word reads
`timescale 1ns/1ps

// What this block does
// (R1) call target is ip plus signed 24-bit displacement
// (R2) extended call takes full 32-bit relative target
// (R3) local calls keep the current stack
// (R4) table call indexes table by procedure number
// (R5) procedure numbers limited to 260 entries
// (R6) table base read from control block at init
// (R7) entry upper 30 bits address, low 2 type
// (R8) type 00 system-local, 10 supervisor, others reserved
// (R9) supervisor call from user switches stacks
// (R10) supervisor stack base cached once at init
// (R11) stack base word part rounded up to 16
// (R12) switch loads trace enable from table bit
// (R13) type 00 calls on current stack, same mode
// (R14) switch saves old trace bit in return type
// (R15) no switch: return type 000 or 001
// (R16) entry target has its type bits cleared
module call_dispatch
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             mem_req_o,
    output logic      [31:0] mem_addr_o,
    input  wire logic        mem_ack_i,
    input  wire logic [31:0] mem_data_i,
    output logic             supervisor_mode_o,
    output logic             trace_enable_bit_o
);

    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'b0001,
        ST_PROCESSOR_CONTROL_BLOCK  = 4'b0010,
        ST_SSP   = 4'b0100,
        ST_FETCH = 4'b1000
    } state_t;

    state_t      state_reg;
    logic [31:0] operand_reg;
    logic [31:0] instruction_pointer;
    logic [31:0] processor_control_block;
    logic [31:0] stack_pointer_reg;
    logic [31:0] frame_pointer_reg;
    logic [31:0] target_reg;
    logic [2:0]  ret_type_reg;
    logic [31:0] table_base_reg;
    logic [31:0] supervisor_stack_base;
    logic        trace_ctl_reg;
    logic        super_reg;
    logic        trace_reg;
    logic        range_err_reg;
    logic        rsvd_err_reg;
    logic [1:0]  type_reg;
    logic        fault_reg;
    logic        boot_reg;
    logic        wr_go;
    logic        cmd_go;
    logic [1:0]  cmd_kind;
    logic        entry_ack;
    logic [1:0]  entry_type;
    logic        do_switch;
    logic [31:0] local_fp;
    logic [31:0] super_fp;
    logic [31:0] disp_ext;
    logic [31:0] wmask;

    localparam int DISP_W_M1       = call_dispatch_pkg::DISP_W - 1;
    localparam int CMD_FAULT_BIT_I = call_dispatch_pkg::CMD_FAULT_BIT;
    localparam int MODE_SUPER_I    = call_dispatch_pkg::MODE_SUPER;
    localparam int MODE_TRACE_I    = call_dispatch_pkg::MODE_TRACE;

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, writes land on the ack edge

    assign wr_go    = ack_o && cyc_i && stb_i && we_i;
    assign cmd_go   = wr_go && adr_i == call_dispatch_pkg::REG_CMD && sel_i[0]
                      && state_reg == ST_IDLE;
    assign cmd_kind = dat_i[1:0];
    assign wmask    = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= cyc_i && stb_i && !ack_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= call_dispatch_pkg::RST_WORD;
        else if (cyc_i && stb_i && !ack_o)
        begin
            unique case (adr_i)
                call_dispatch_pkg::REG_OPERAND: dat_o <= operand_reg;
                call_dispatch_pkg::REG_IP:      dat_o <= instruction_pointer;
                call_dispatch_pkg::REG_PROCESSOR_CONTROL_BLOCK:    dat_o <= processor_control_block;
                call_dispatch_pkg::REG_SP:      dat_o <= stack_pointer_reg;
                call_dispatch_pkg::REG_FP:      dat_o <= frame_pointer_reg;
                call_dispatch_pkg::REG_STATUS:
                    dat_o <= {22'h000000, type_reg, 3'h0, rsvd_err_reg, range_err_reg,
                              trace_reg, super_reg, state_reg != ST_IDLE};
                call_dispatch_pkg::REG_TARGET:  dat_o <= target_reg;
                call_dispatch_pkg::REG_RETTYPE: dat_o <= {29'h00000000, ret_type_reg};
                call_dispatch_pkg::REG_TBASE:   dat_o <= table_base_reg;
                call_dispatch_pkg::REG_SSP:     dat_o <= supervisor_stack_base;
                call_dispatch_pkg::REG_MODE:    dat_o <= {30'h00000000, trace_reg, super_reg};
                default:                        dat_o <= call_dispatch_pkg::RST_WORD;
            endcase
        end
    end

    // operand and control block pointer are plain software registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            operand_reg             <= call_dispatch_pkg::RST_WORD;
            processor_control_block <= call_dispatch_pkg::RST_PROCESSOR_CONTROL_BLOCK;
        end
        else if (wr_go)
        begin
            if (adr_i == call_dispatch_pkg::REG_OPERAND)
                operand_reg <= (operand_reg & ~wmask) | (dat_i & wmask);
            if (adr_i == call_dispatch_pkg::REG_PROCESSOR_CONTROL_BLOCK)
                processor_control_block <= (processor_control_block & ~wmask)
                                           | (dat_i & wmask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // call arithmetic

    assign disp_ext   = {{8{operand_reg[DISP_W_M1]}}, operand_reg[DISP_W_M1:0]}; // [R1]
    assign entry_ack  = state_reg == ST_FETCH && mem_ack_i;
    assign entry_type = mem_data_i[1:0];                                          // [R7]
    assign do_switch  = entry_type == call_dispatch_pkg::ENTRY_SUPER && !super_reg; // [R9]
    assign local_fp   = (stack_pointer_reg + call_dispatch_pkg::ALIGN_ADD)
                        & call_dispatch_pkg::ALIGN_MASK;                          // [R3]
    // low two bits dropped before rounding so a sloppy base still lands aligned
    assign super_fp   = ((supervisor_stack_base & call_dispatch_pkg::WORD_MASK)
                        + call_dispatch_pkg::ALIGN_ADD) & call_dispatch_pkg::ALIGN_MASK; // [R11]

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: init walk and table entry fetch

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg  <= ST_IDLE;
            mem_req_o  <= 1'b0;
            mem_addr_o <= call_dispatch_pkg::RST_WORD;
            boot_reg   <= 1'b1;
        end
        else
        begin
            boot_reg <= 1'b0;
            unique case (state_reg)
                ST_IDLE:
                    if (boot_reg || (cmd_go && cmd_kind == call_dispatch_pkg::CMD_INIT))
                    begin
                        state_reg  <= ST_PROCESSOR_CONTROL_BLOCK;
                        mem_req_o  <= 1'b1;
                        mem_addr_o <= processor_control_block
                                      + call_dispatch_pkg::PROCESSOR_CONTROL_BLOCK_TABLE_OFF; // [R6]
                    end
                    else if (cmd_go && cmd_kind == call_dispatch_pkg::CMD_CALLS
                             && operand_reg < call_dispatch_pkg::TABLE_ENTRIES) // [R5]
                    begin
                        state_reg  <= ST_FETCH;
                        mem_req_o  <= 1'b1;
                        mem_addr_o <= table_base_reg + call_dispatch_pkg::TABLE_ENTRY_OFF
                                      + {operand_reg[29:0], 2'b00};         // [R4]
                    end
                ST_PROCESSOR_CONTROL_BLOCK:
                    if (mem_ack_i)
                    begin
                        state_reg  <= ST_SSP;
                        mem_addr_o <= mem_data_i + call_dispatch_pkg::TABLE_SSP_OFF; // [R10]
                    end
                ST_SSP, ST_FETCH:
                    if (mem_ack_i)
                    begin
                        state_reg <= ST_IDLE;
                        mem_req_o <= 1'b0;
                    end
            endcase
        end
    end

    // cached table pointers; trace control bit shares the stack base word
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            table_base_reg        <= call_dispatch_pkg::RST_WORD;
            supervisor_stack_base <= call_dispatch_pkg::RST_WORD;
            trace_ctl_reg         <= 1'b0;
        end
        else if (mem_ack_i && state_reg == ST_PROCESSOR_CONTROL_BLOCK)
            table_base_reg <= mem_data_i;                                  // [R6]
        else if (mem_ack_i && state_reg == ST_SSP)
        begin
            supervisor_stack_base <= mem_data_i;                           // [R10]
            trace_ctl_reg         <= mem_data_i[0];                        // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // processor state updated by calls; software may also load ip, sp and mode when idle

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            instruction_pointer <= call_dispatch_pkg::RST_WORD;
            stack_pointer_reg   <= call_dispatch_pkg::RST_WORD;
            frame_pointer_reg   <= call_dispatch_pkg::RST_WORD;
            target_reg          <= call_dispatch_pkg::RST_WORD;
            ret_type_reg        <= call_dispatch_pkg::RET_LOCAL;
            super_reg           <= 1'b0;
            trace_reg           <= 1'b0;
            range_err_reg       <= 1'b0;
            rsvd_err_reg        <= 1'b0;
            type_reg            <= call_dispatch_pkg::ENTRY_LOCAL;
            fault_reg           <= 1'b0;
        end
        else if (cmd_go)
        begin
            range_err_reg <= 1'b0;
            rsvd_err_reg  <= 1'b0;
            fault_reg     <= dat_i[CMD_FAULT_BIT_I];
            if (cmd_kind == call_dispatch_pkg::CMD_CALL || cmd_kind == call_dispatch_pkg::CMD_CALLX)
            begin
                // local calls never touch mode or stack selection  [R3]
                instruction_pointer <= instruction_pointer + ((cmd_kind
                                       == call_dispatch_pkg::CMD_CALL) ? disp_ext
                                       : operand_reg);                     // [R1] [R2]
                target_reg          <= instruction_pointer + ((cmd_kind
                                       == call_dispatch_pkg::CMD_CALL) ? disp_ext
                                       : operand_reg);
                frame_pointer_reg   <= local_fp;                           // [R3]
                stack_pointer_reg   <= local_fp + call_dispatch_pkg::FRAME_BYTES;
                ret_type_reg        <= call_dispatch_pkg::RET_LOCAL;
            end
            else if (cmd_kind == call_dispatch_pkg::CMD_CALLS
                     && operand_reg >= call_dispatch_pkg::TABLE_ENTRIES)
                range_err_reg <= 1'b1;                                     // [R5]
        end
        else if (entry_ack)
        begin
            type_reg <= entry_type;
            if (entry_type == call_dispatch_pkg::ENTRY_LOCAL
                || entry_type == call_dispatch_pkg::ENTRY_SUPER)           // [R8]
            begin
                instruction_pointer <= mem_data_i & call_dispatch_pkg::WORD_MASK; // [R16]
                target_reg          <= mem_data_i & call_dispatch_pkg::WORD_MASK; // [R7]
                if (do_switch)
                begin
                    super_reg         <= 1'b1;                             // [R9]
                    trace_reg         <= trace_ctl_reg;                    // [R12]
                    ret_type_reg      <= {call_dispatch_pkg::RET_SUPER_HI, trace_reg}; // [R14]
                    frame_pointer_reg <= super_fp;                         // [R11]
                    stack_pointer_reg <= super_fp + call_dispatch_pkg::FRAME_BYTES;
                end
                else
                begin
                    ret_type_reg      <= fault_reg ? call_dispatch_pkg::RET_FAULT
                                         : call_dispatch_pkg::RET_LOCAL;  // [R15] [R13]
                    frame_pointer_reg <= local_fp;                         // [R13]
                    stack_pointer_reg <= local_fp + call_dispatch_pkg::FRAME_BYTES;
                end
            end
            else
                rsvd_err_reg <= 1'b1;                                      // [R8]
        end
        else if (wr_go && state_reg == ST_IDLE)
        begin
            if (adr_i == call_dispatch_pkg::REG_IP)
                instruction_pointer <= (instruction_pointer & ~wmask) | (dat_i & wmask);
            if (adr_i == call_dispatch_pkg::REG_SP)
                stack_pointer_reg <= (stack_pointer_reg & ~wmask) | (dat_i & wmask);
            if (adr_i == call_dispatch_pkg::REG_MODE && sel_i[0])
            begin
                super_reg <= dat_i[MODE_SUPER_I];
                trace_reg <= dat_i[MODE_TRACE_I];
            end
        end
    end

    assign supervisor_mode_o  = super_reg;
    assign trace_enable_bit_o = trace_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_call_disp;
        cmd_go && cmd_kind == call_dispatch_pkg::CMD_CALL |=> instruction_pointer
            == $past(instruction_pointer) + {{8{$past(operand_reg[23])}}, $past(operand_reg[23:0])};
    endproperty
    a_call_disp: assert property (p_call_disp) else $error("call target wrong"); // [R1]

    property p_callx;
        cmd_go && cmd_kind == call_dispatch_pkg::CMD_CALLX |=>
            instruction_pointer == $past(instruction_pointer) + $past(operand_reg);
    endproperty
    a_callx: assert property (p_callx) else $error("extended call target wrong"); // [R2]

    property p_local_stack;
        cmd_go && cmd_kind[1] == 1'b0 |=> $stable(super_reg)
            && frame_pointer_reg == (($past(stack_pointer_reg) + 32'h0000_000F) & 32'hFFFF_FFF0);
    endproperty
    a_local_stack: assert property (p_local_stack) else $error("local call moved stack"); // [R3]

    property p_fetch_addr;
        cmd_go && cmd_kind == call_dispatch_pkg::CMD_CALLS && operand_reg < 32'h0000_0104
        |=> mem_req_o && mem_addr_o == table_base_reg + 32'h0000_0030 + ($past(operand_reg) << 2);
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("entry fetch address wrong"); // [R4]

    property p_range;
        cmd_go && cmd_kind == call_dispatch_pkg::CMD_CALLS && operand_reg >= 32'h0000_0104
        |=> range_err_reg && !mem_req_o [*2];
    endproperty
    a_range: assert property (p_range) else $error("out of range number fetched"); // [R5]

    property p_init_walk;
        state_reg == ST_PROCESSOR_CONTROL_BLOCK && mem_ack_i |=> mem_addr_o == $past(mem_data_i) + 32'h0000_000C
            && table_base_reg == $past(mem_data_i);
    endproperty
    a_init_walk: assert property (p_init_walk) else $error("init walk wrong"); // [R6]

    property p_entry_target;
        entry_ack && !mem_data_i[0] |=> instruction_pointer == {$past(mem_data_i[31:2]), 2'b00};
    endproperty
    a_entry_target: assert property (p_entry_target) else $error("entry target wrong"); // [R16]

    property p_reserved;
        entry_ack && mem_data_i[0] |=> rsvd_err_reg && $stable(super_reg)
            && $stable(instruction_pointer);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved type acted on"); // [R8]

    property p_switch;
        entry_ack && mem_data_i[1:0] == 2'h2 && !super_reg |=> super_reg
            && trace_reg == $past(trace_ctl_reg) && ret_type_reg == {2'b01, $past(trace_reg)}
            && frame_pointer_reg == ((($past(supervisor_stack_base) & 32'hFFFF_FFFC)
               + 32'h0000_000F) & 32'hFFFF_FFF0);
    endproperty
    a_switch: assert property (p_switch) else $error("supervisor switch wrong"); // [R12]

    property p_no_switch;
        entry_ack && !mem_data_i[0] && (super_reg || !mem_data_i[1]) |=> $stable(super_reg)
            && ret_type_reg == ($past(fault_reg) ? 3'h1 : 3'h0);
    endproperty
    a_no_switch: assert property (p_no_switch) else $error("no-switch return type wrong"); // [R15]

    c_local:  cover property (entry_ack && mem_data_i[1:0] == 2'h0);
    c_switch: cover property (entry_ack && mem_data_i[1:0] == 2'h2 && !super_reg);
    c_stay:   cover property (entry_ack && mem_data_i[1:0] == 2'h2 && super_reg);
    c_init:   cover property (state_reg == ST_SSP && mem_ack_i);

endmodule : call_dispatch

// [test/table_memory.sv]
// word memory holding the control block and the procedure table
// assumes one outstanding read whose request is held until answered
`timescale 1ns/1ps
module table_memory
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        slow_i,
    input  wire logic        mem_req_i,
    input  wire logic [31:0] mem_addr_i,
    output logic             mem_ack_o,
    output logic      [31:0] mem_data_o
);
    logic [31:0] word_reg = 32'h0000_0000;
    logic [1:0]  wait_reg;

    function automatic logic [31:0] lookup(input logic [31:0] a);
        case (a)
            32'h0000_0014: return 32'h0000_1000; // table base pointer
            32'h0000_100C: return 32'h0000_2005; // unaligned base, trace bit 1
            32'h0000_1030: return 32'h0000_4000; // local entry
            32'h0000_1034: return 32'h0000_5002; // supervisor entry
            32'h0000_1038: return 32'h0000_6001; // reserved entry
            32'h0000_143C: return 32'h0000_8000; // last entry
            default:       return ~a;
        endcase
    endfunction : lookup

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i)
    begin
        if (rst_i || mem_ack_o || !mem_req_i)
        begin
            mem_ack_o <= 1'b0;
            wait_reg  <= 2'h0;
        end
        else if (wait_reg == (slow_i ? 2'h3 : 2'h0))
        begin
            mem_ack_o <= 1'b1;
            word_reg  <= lookup(mem_addr_i);
        end
        else
            wait_reg <= wait_reg + 2'h1;
    end
    // idle lines show the inverse so a stale sample never matches
    assign mem_data_o = mem_ack_o ? word_reg : ~word_reg;
endmodule : table_memory

// [test/call_dispatch_test.sv]
// self-checking bench for the call dispatch block
// assumes the table memory model on the memory port
`timescale 1ns/1ps
module call_dispatch_test;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0000_0000;
    logic        slow  = 1'b0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        mem_req_o;
    logic [31:0] mem_addr_o;
    logic        mem_ack_i;
    logic [31:0] mem_data_i;
    logic        sup_o;
    logic        trc_o;
    int          err_total = 0;
    int          compares  = 0;

    call_dispatch dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
        .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i),
        .supervisor_mode_o(sup_o), .trace_enable_bit_o(trc_o));
    table_memory mem_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .mem_req_i(mem_req_o),
        .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_data_o(mem_data_i));

    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task print_verdict;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // holds the request until ack is sampled high at a rising edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do
            @(posedge clk_i);
        while (ack_o !== 1'b1 && n++ < 40);
        if (ack_o !== 1'b1)
            chk(32'h0000_0000, 32'h0000_0001);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask : wb

    task wait_idle;
        logic [31:0] q;
        int          n;
        n = 0;
        q = 32'h0000_0001;
        while (q[call_dispatch_pkg::ST_BUSY] !== 1'b0 && n++ < 40)
            wb(1'b0, call_dispatch_pkg::REG_STATUS, 32'h0, q);
        if (q[call_dispatch_pkg::ST_BUSY] !== 1'b0)
            chk(32'h0000_0000, 32'h0000_0001);
    endtask : wait_idle

    task run(input logic [31:0] cmd, input logic [31:0] op);
        logic [31:0] q;
        wb(1'b1, call_dispatch_pkg::REG_OPERAND, op, q);
        wb(1'b1, call_dispatch_pkg::REG_CMD, cmd, q);
        wait_idle;
    endtask : run

    task rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q & mask, exp);
    endtask : rd_chk

    task check_call(input logic [31:0] ip, fp, sp, input logic [2:0] rt);
        rd_chk(call_dispatch_pkg::REG_IP, 32'hFFFF_FFFF, ip);
        rd_chk(call_dispatch_pkg::REG_TARGET, 32'hFFFF_FFFF, ip);
        rd_chk(call_dispatch_pkg::REG_FP, 32'hFFFF_FFFF, fp);
        rd_chk(call_dispatch_pkg::REG_SP, 32'hFFFF_FFFF, sp);
        rd_chk(call_dispatch_pkg::REG_RETTYPE, 32'h0000_0007, {29'h0, rt});
    endtask : check_call

    ////////////////////////////////////////////////////////////////////////////
    task t_init;
        wait_idle;
        rd_chk(call_dispatch_pkg::REG_TBASE, 32'hFFFF_FFFF, 32'h0000_1000);
        rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
        run(32'h3, 32'h0);
        rd_chk(call_dispatch_pkg::REG_TBASE, 32'hFFFF_FFFF, 32'h0000_1000);
        rd_chk(call_dispatch_pkg::REG_SSP, 32'hFFFF_FFFF, 32'h0000_2005);
        $display("test init done");
    endtask : t_init

    task t_local;
        logic [31:0] q;
        wb(1'b1, call_dispatch_pkg::REG_IP, 32'h0000_0100, q);
        wb(1'b1, call_dispatch_pkg::REG_SP, 32'h0000_3001, q);
        run(32'h0, 32'h00FF_FFFC);
        check_call(32'h0000_00FC, 32'h0000_3010, 32'h0000_3050, 3'h0);
        run(32'h0, 32'h007F_FFFC);
        check_call(32'h0080_00F8, 32'h0000_3050, 32'h0000_3090, 3'h0);
        run(32'h1, 32'h8000_0000);
        check_call(32'h8080_00F8, 32'h0000_3090, 32'h0000_30D0, 3'h0);
        rd_chk(call_dispatch_pkg::REG_MODE, 32'h0000_0003, 32'h0000_0000);
        $display("test local done");
    endtask : t_local

    task t_table;
        run(32'h2, 32'h0);
        check_call(32'h0000_4000, 32'h0000_30D0, 32'h0000_3110, 3'h0);
        run(32'h6, 32'h0);
        check_call(32'h0000_4000, 32'h0000_3110, 32'h0000_3150, 3'h1);
        run(32'h2, 32'd259);
        check_call(32'h0000_8000, 32'h0000_3150, 32'h0000_3190, 3'h0);
        run(32'h2, 32'd260);
        rd_chk(call_dispatch_pkg::REG_STATUS, 32'h0000_001F, 32'h0000_0008);
        run(32'h2, 32'd2);
        rd_chk(call_dispatch_pkg::REG_STATUS, 32'h0000_001F, 32'h0000_0010);
        rd_chk(call_dispatch_pkg::REG_IP, 32'hFFFF_FFFF, 32'h0000_8000);
        $display("test table done");
    endtask : t_table

    task t_super;
        run(32'h2, 32'd1);
        check_call(32'h0000_5000, 32'h0000_2010, 32'h0000_2050, 3'h2);
        rd_chk(call_dispatch_pkg::REG_STATUS, 32'h0000_001F, 32'h0000_0006);
        chk({30'h0, sup_o, trc_o}, 32'h0000_0003);
        run(32'h2, 32'd1);
        check_call(32'h0000_5000, 32'h0000_2050, 32'h0000_2090, 3'h0);
        chk({31'h0, sup_o}, 32'h0000_0001);
        $display("test super done");
    endtask : t_super

    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_init;
        t_local;
        slow <= 1'b1;
        t_table;
        t_super;
        print_verdict;
    end

    // the whole run needs a few hundred cycles
    initial
    begin
        #60000;
        chk(32'h0000_0000, 32'h0000_0001);
        print_verdict;
    end
endmodule : call_dispatch_test
